// [rtl/fwa_pkg.sv]
package fwa_pkg;

  // ------------------------------------------------------------
  // Register port geometry and map
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h2;
  localparam logic [ADDR_W-1:0] REG_THR = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] REG_FLAG = 4'h6;

  // ------------------------------------------------------------
  // Command codes, field positions and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_ALL = 8'h03;
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_ON_RESET = 1'h1;
  localparam logic CTRL_RUN_RESET = 1'h0;
  localparam int CFG_INV_BIT = 15;
  localparam int THR_W = 12;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h1000;
  localparam logic [THR_W-1:0] THR_RESET = 12'h000;
  localparam logic [6:0] BUS_ADDR_RESET = 7'h10;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam int SMB_BITS = 8;

  // ------------------------------------------------------------
  // Status sources: bit index in the status word
  // ------------------------------------------------------------
  localparam int NSRC = 13;
  localparam int NPIN = 5;
  localparam int IDX_VOUT_UV = 9;
  localparam int IDX_SW_HEALTH = 12;
  localparam logic [NSRC-1:0] FAULT_MASK = 13'h0007;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr;
    logic rd;
  } fwa_bus_t;

  // Warning conditions from the monitor and bus engine
  typedef struct packed {
    logic switch_health_warning;
    logic input_power_warning;
    logic vout_high;
    logic vin_high;
    logic vin_low;
    logic iout_second;
    logic iout_high;
    logic regulation_timer_active;
    logic comm_error_warning;
  } fwa_warn_t;

  // One output voltage sample from the converter
  typedef struct packed {
    logic valid;
    logic [THR_W-1:0] code;
  } fwa_sample_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ACK = 5'h04,
    ST_DATA = 5'h08,
    ST_NACK = 5'h10
  } fwa_ara_state_t;

endpackage

// [rtl/fwa_sync.sv]
module fwa_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// [rtl/fwa_ara.sv]
module fwa_ara (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] own_addr_in,
  input wire logic alert_in,
  output logic sda_oe_out,
  output logic win_out
);
  import fwa_pkg::*;

  fwa_ara_state_t state;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] data;

  // ------------------------------------------------------------
  // Bus edge and condition detection
  // ------------------------------------------------------------
  wire scl_rise = scl_in && !scl_q;
  wire scl_fall = !scl_in && scl_q;
  wire start_c = scl_in && scl_q && sda_q && !sda_in;
  wire stop_c = scl_in && scl_q && !sda_q && sda_in;
  wire cnt_full = cnt == 4'(SMB_BITS);
  wire ara_hit = (shreg == {ARA_ADDR, 1'h1}) && alert_in;
  wire lose = scl_rise && data[7] && !sda_in;

  // Previous line levels for edge detection
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Alert response: ack the read address, send own address, arbitrate
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      data <= 8'hff;
      sda_oe_out <= 1'h0;
      win_out <= 1'h0;
    end else begin
      win_out <= 1'h0;
      if (start_c) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe_out <= 1'h0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe_out <= 1'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_in};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt_full) begin
              state <= ara_hit ? ST_ACK : ST_IDLE;
              sda_oe_out <= ara_hit;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state <= ST_DATA;
              data <= {own_addr_in, 1'h1};
              sda_oe_out <= !own_addr_in[6];
              cnt <= 4'h0;
            end
          end
          ST_DATA: begin
            if (lose) begin
              state <= ST_IDLE;
              sda_oe_out <= 1'h0;
            end else if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt_full) begin
              state <= ST_NACK;
              sda_oe_out <= 1'h0;
              win_out <= 1'h1;
            end else if (scl_fall) begin
              data <= {data[6:0], 1'h1};
              sda_oe_out <= !data[6];
            end
          end
          ST_NACK: begin
            if (scl_fall) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ack_alert;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(state == ST_ACK) |-> $past(alert_in) && sda_oe_out;
  endproperty
  a_ack_alert: assert property (p_ack_alert)
    else $error("ara acked without active alert");

  property p_lost;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == ST_DATA && lose && !start_c && !stop_c)
      |=> state == ST_IDLE && !sda_oe_out && !win_out;
  endproperty
  a_lost: assert property (p_lost)
    else $error("lost arbitration but kept sending");
endmodule

// [rtl/fwa_alert_top.sv]
// The implementer's own choices: strobed register access and the register addresses.
module fwa_alert_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire fwa_pkg::fwa_bus_t bus_in,
  output logic [fwa_pkg::DATA_W-1:0] rd_data_out,
  input wire logic uv_pin_in,
  input wire logic ov_pin_in,
  input wire logic oc_timeout_in,
  input wire fwa_pkg::fwa_warn_t warn_in,
  input wire fwa_pkg::fwa_sample_t vout_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic alert_output_pin_out,
  output logic alert_output_pin_oe_out,
  output logic hs_on_out
);
  import fwa_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [NPIN-1:0] pin_sync;
  logic op_on;
  logic mon_run;
  logic [DATA_W-1:0] cfg;
  logic [THR_W-1:0] thr;
  logic [6:0] bus_addr;
  logic [NSRC-1:0] status;
  logic alert_act;
  logic od_low;
  logic ara_win;

  // Write strobe decode, used for every writable register
  function automatic logic hit(input fwa_bus_t b,
                               input logic [ADDR_W-1:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Fault pins and bus lines come from outside the clock domain
  fwa_sync #(.W(NPIN)) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in({sda_in, scl_in, oc_timeout_in, ov_pin_in, uv_pin_in}),
    .q_out(pin_sync)
  );

  // Alert response responder on the two-wire bus
  fwa_ara u_ara (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .scl_in(pin_sync[3]),
    .sda_in(pin_sync[4]),
    .own_addr_in(bus_addr),
    .alert_in(alert_act),
    .sda_oe_out(sda_oe_out),
    .win_out(ara_win)
  );

  // ------------------------------------------------------------
  // Command and write decode
  // ------------------------------------------------------------
  wire clr_cmd = hit(bus_in, REG_CMD)
    && (bus_in.data[7:0] == CMD_CLEAR_ALL);
  wire ctrl_wr = hit(bus_in, REG_CTRL);
  wire cycle_on = ctrl_wr && bus_in.data[CTRL_ON_BIT] && !op_on;
  wire clr_all = clr_cmd || cycle_on;
  wire inv = cfg[CFG_INV_BIT];

  // ------------------------------------------------------------
  // Status sources and latching
  // ------------------------------------------------------------
  // Output undervoltage compare only while sampling runs
  wire vout_low = mon_run && vout_in.valid
    && (vout_in.code < thr);
  wire [NSRC-1:0] cond = {
    warn_in.switch_health_warning,
    warn_in.input_power_warning,
    warn_in.vout_high,
    vout_low,
    warn_in.vin_high,
    warn_in.vin_low,
    warn_in.iout_second,
    warn_in.iout_high,
    warn_in.regulation_timer_active,
    warn_in.comm_error_warning,
    pin_sync[2:0]
  };
  // Set wins over clear; clear only drops bits whose cause is gone
  wire [NSRC-1:0] next_status = cond
    | (status & ~{NSRC{clr_all}});
  // Rising enabled bits only; an already set bit cannot retrigger
  wire [NSRC-1:0] rise = next_status & ~status
    & cfg[NSRC-1:0];
  wire next_alert = (|rise)
    || (alert_act && !clr_all && !ara_win);
  wire next_op_on = ctrl_wr ? bus_in.data[CTRL_ON_BIT] : op_on;
  // Only the fault bits gate the output; warnings never do
  wire next_hs_on = next_op_on
    && !(|(next_status & FAULT_MASK));

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire [DATA_W-1:0] ctrl_rd = DATA_W'({op_on, 6'h00, mon_run});
  wire [DATA_W-1:0] stat_rd = DATA_W'(status);
  wire [DATA_W-1:0] flag_rd = DATA_W'({hs_on_out, alert_act});
  wire [DATA_W-1:0] rd_mux =
    (bus_in.addr == REG_CTRL) ? ctrl_rd :
    (bus_in.addr == REG_CFG) ? cfg :
    (bus_in.addr == REG_THR) ? DATA_W'(thr) :
    (bus_in.addr == REG_STAT) ? stat_rd :
    (bus_in.addr == REG_ADDR) ? DATA_W'(bus_addr) :
    (bus_in.addr == REG_FLAG) ? flag_rd : '0;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= bus_in.rd ? rd_mux : '0;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Output control and monitor run
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_on <= CTRL_ON_RESET;
      mon_run <= CTRL_RUN_RESET;
    end else if (ctrl_wr) begin
      op_on <= bus_in.data[CTRL_ON_BIT];
      mon_run <= bus_in.data[CTRL_RUN_BIT];
    end
  end

  // Alert enables and inversion, switch health enabled at reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg <= CFG_RESET;
    end else if (hit(bus_in, REG_CFG)) begin
      cfg <= bus_in.data;
    end
  end

  // Low threshold for the output voltage and own bus address
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      thr <= THR_RESET;
      bus_addr <= BUS_ADDR_RESET;
    end else begin
      if (hit(bus_in, REG_THR)) begin
        thr <= bus_in.data[THR_W-1:0];
      end
      if (hit(bus_in, REG_ADDR)) begin
        bus_addr <= bus_in.data[6:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Status, alert and output state
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status <= '0;
      alert_act <= 1'h0;
      hs_on_out <= 1'h0;
    end else begin
      status <= next_status;
      alert_act <= next_alert;
      hs_on_out <= next_hs_on;
    end
  end

  // Open-drain pins: only ever pull low, released from reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      od_low <= 1'h0;
      alert_output_pin_oe_out <= 1'h0;
    end else begin
      od_low <= 1'h0;
      alert_output_pin_oe_out <= alert_act ^ inv;
    end
  end
  assign alert_output_pin_out = od_low;
  assign sda_out = od_low;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_quiet;
    !alert_act ##1 !alert_output_pin_oe_out;
  endsequence

  sequence s_loud;
    alert_act ##1 alert_output_pin_oe_out;
  endsequence

  property p_fault_off;
    (|(status & FAULT_MASK)) |-> !hs_on_out;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("hot swap output on with a fault latched");

  // The output flop leaves reset one edge after the control register
  property p_warn_keep;
    ($past(rstn_in) && op_on && !(|(status & FAULT_MASK)))
      |-> hs_on_out;
  endproperty
  a_warn_keep: assert property (p_warn_keep)
    else $error("output off without a fault");

  property p_latch;
    !clr_all |=> ((status & $past(status)) == $past(status));
  endproperty
  a_latch: assert property (p_latch)
    else $error("status bit dropped without a clear");

  property p_clear;
    clr_all |=> status == $past(cond);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left a bit whose cause was gone");

  property p_rise_alert;
    (|rise) |=> alert_act;
  endproperty
  a_rise_alert: assert property (p_rise_alert)
    else $error("enabled rising bit did not alert");

  property p_no_retrig;
    (!alert_act && !(|rise)) |=> !alert_act;
  endproperty
  a_no_retrig: assert property (p_no_retrig)
    else $error("alert without a rising enabled bit");

  property p_clear_deassert;
    (clr_all && !(|rise) && !inv) |=> s_quiet;
  endproperty
  a_clear_deassert: assert property (p_clear_deassert)
    else $error("alert stayed active after clear");

  property p_vout_low;
    (vout_low && cfg[IDX_VOUT_UV] && !status[IDX_VOUT_UV] && !inv
      && !hit(bus_in, REG_CFG)) |=> s_loud;
  endproperty
  a_vout_low: assert property (p_vout_low)
    else $error("low output sample did not drive the alert pin");

  property p_win;
    (ara_win && !(|rise)) |=> !alert_act;
  endproperty
  a_win: assert property (p_win)
    else $error("alert kept after winning the response");

  property p_set;
    (|cond) |=> ((status & $past(cond)) == $past(cond));
  endproperty
  a_set: assert property (p_set)
    else $error("active condition did not set its status bit");

  property p_ctrl_off;
    (ctrl_wr && !bus_in.data[CTRL_ON_BIT]) |=> !hs_on_out;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off)
    else $error("output stayed on after an off command");

  property p_pin_level;
    (!inv && !hit(bus_in, REG_CFG))
      |=> alert_output_pin_oe_out == $past(alert_act);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("alert pin does not follow the alert state");

  property p_clear_drop;
    (clr_all && !(|rise)) |=> !alert_act;
  endproperty
  a_clear_drop: assert property (p_clear_drop)
    else $error("alert kept through a clear with no new bit");
endmodule

// [sim/fwa_host_model.sv]
// ------------------------------------------------------------
// Bus host model: drives the clock line and runs receive-byte reads
// ------------------------------------------------------------
module fwa_host_model (
  input wire logic clk_in,
  input wire logic dev_oe_in,
  input wire logic alert_oe_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import fwa_pkg::*;

  logic host_oe = 1'b0;
  logic rival_oe = 1'b0;

  // Open-drain data line with pull-up, every party may pull low
  assign sda_out = ~(dev_oe_in | host_oe | rival_oe);

  initial scl_out = 1'b1;

  // Half a bus bit, long enough for the device's line synchronisers
  task automatic half();
    repeat (6) @(posedge clk_in);
  endtask

  // Alert response read; an optional rival device joins the data phase
  task automatic ara_read(input logic [6:0] rival, input logic rival_on,
                          output logic [7:0] data, output logic acked,
                          output logic alert_nack);
    logic [7:0] a;
    logic [7:0] r;
    logic rival_lost;
    a = {ARA_ADDR, 1'b1};
    r = {rival, 1'b1};
    rival_lost = 1'b0;
    @(posedge clk_in);
    host_oe <= 1'b1;
    half();
    scl_out <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      host_oe <= ~a[i];
      half();
      scl_out <= 1'b1;
      half();
      scl_out <= 1'b0;
    end
    host_oe <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    acked = ~sda_out;
    scl_out <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      rival_oe <= rival_on & ~rival_lost & ~r[i];
      half();
      scl_out <= 1'b1;
      half();
      data[i] = sda_out;
      // A rival that sent a one but sees a zero drops out
      rival_lost = rival_lost | (r[i] & ~sda_out);
      scl_out <= 1'b0;
    end
    // Host leaves the line high for the not-acknowledge bit
    rival_oe <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    alert_nack = alert_oe_in;
    scl_out <= 1'b0;
    host_oe <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    host_oe <= 1'b0;
    half();
  endtask
endmodule

// [sim/tb_fwa_alert_top.sv]
module tb_fwa_alert_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fwa_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  fwa_bus_t bus = '0;
  fwa_warn_t warn = '0;
  fwa_sample_t vout = '0;
  logic [2:0] fpin = 3'h0;
  logic [15:0] rd_data;
  logic scl;
  logic sda;
  logic sda_oe;
  logic al_oe;
  logic hs_on;
  logic sda_lvl;
  logic al_lvl;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] v;
  logic [15:0] cfg;
  logic [7:0] d;
  logic ack;
  logic an;
  logic [3:0] ra [8] = '{REG_CMD, REG_CTRL, REG_CFG, REG_THR, REG_STAT,
                         REG_ADDR, REG_FLAG, 4'h9};
  logic [15:0] rv [8] = '{16'h0000, 16'h0080, 16'h1000, 16'h0000,
                          16'h0000, 16'h0010, 16'h0002, 16'h0000};

  fwa_alert_top fwa_alert_top_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus),
    .rd_data_out(rd_data), .uv_pin_in(fpin[0]), .ov_pin_in(fpin[1]),
    .oc_timeout_in(fpin[2]), .warn_in(warn), .vout_in(vout),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_lvl), .sda_oe_out(sda_oe),
    .alert_output_pin_out(al_lvl), .alert_output_pin_oe_out(al_oe),
    .hs_on_out(hs_on)
  );

  fwa_host_model fwa_host_model_i (
    .clk_in(clk_in), .dev_oe_in(sda_oe), .alert_oe_in(al_oe),
    .scl_out(scl), .sda_out(sda)
  );

  // Clock and hang guard
  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk_in);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.data <= dat;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic clear_all();
    wr(REG_CMD, {8'h00, CMD_CLEAR_ALL});
    wait_n(4);
  endtask

  task automatic pulse_warn(input int k);
    @(posedge clk_in);
    warn[k] <= 1'b1;
    @(posedge clk_in);
    warn <= '0;
    wait_n(4);
  endtask

  task automatic sample(input logic [11:0] c);
    @(posedge clk_in);
    vout <= '{valid: 1'b1, code: c};
    @(posedge clk_in);
    vout.valid <= 1'b0;
    wait_n(4);
  endtask

  // Status bit that a warning field sets
  function automatic int stat_idx(input int k);
    return (k < 6) ? k + 3 : k + 4;
  endfunction

  function automatic logic [15:0] bit_of(input int i);
    return 16'h0001 << i;
  endfunction

  // Address that wins arbitration between two responders
  function automatic logic [6:0] lower(input logic [6:0] a,
                                       input logic [6:0] b);
    return (a < b) ? a : b;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    v = 16'($urandom(32'h2950d754));
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_n(4);
    for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
    chk(16'(al_oe), 16'h0000);
    chk(16'({sda_lvl, al_lvl}), 16'h0000);
    pulse_warn(8);
    chk(16'(al_oe), 16'h0001);
    clear_all();
    $display("reset values done");
    // Each fault source, persisting then gone
    for (int f = 0; f < 3; f++) begin
      @(posedge clk_in);
      fpin <= 3'(1 << f);
      wait_n(6);
      chk(16'(hs_on), 16'h0000);
      rchk(REG_STAT, bit_of(f));
      clear_all();
      rchk(REG_STAT, bit_of(f));
      @(posedge clk_in);
      fpin <= 3'h0;
      wait_n(6);
      rchk(REG_STAT, bit_of(f));
      if (f == 2) begin
        wr(REG_CTRL, 16'h0000);
        wr(REG_CTRL, 16'h0080);
        wait_n(4);
      end else begin
        clear_all();
      end
      rchk(REG_STAT, 16'h0000);
      chk(16'(hs_on), 16'h0001);
    end
    $display("faults done");
    // Every warning under a random enable mask
    for (int k = 0; k < 9; k++) begin
      cfg = 16'($urandom()) & 16'h1ff8;
      wr(REG_CFG, cfg);
      pulse_warn(k);
      rchk(REG_STAT, bit_of(stat_idx(k)));
      chk(16'(al_oe), 16'(cfg[stat_idx(k)]));
      chk(16'(hs_on), 16'h0001);
      clear_all();
      chk(16'(al_oe), 16'h0000);
      rchk(REG_STAT, 16'h0000);
    end
    wr(REG_CFG, 16'h9000);
    wait_n(3);
    chk(16'(al_oe), 16'h0001);
    pulse_warn(8);
    chk(16'(al_oe), 16'h0000);
    clear_all();
    $display("warnings done");
    // Output low threshold with monitor stopped, then running
    wr(REG_THR, 16'h0100);
    rchk(REG_THR, 16'h0100);
    wr(REG_CFG, 16'h0200);
    sample(12'h0ff);
    chk(16'(al_oe), 16'h0000);
    wr(REG_CTRL, 16'h0081);
    sample(12'h100);
    chk(16'(al_oe), 16'h0000);
    sample(12'h0ff);
    chk(16'(al_oe), 16'h0001);
    clear_all();
    chk(16'(al_oe), 16'h0000);
    sample(12'h0ff);
    chk(16'(al_oe), 16'h0001);
    wr(REG_CTRL, 16'h0080);
    clear_all();
    // Persisting fault does not re-alert after clear
    wr(REG_CFG, 16'h0001);
    @(posedge clk_in);
    fpin <= 3'h1;
    wait_n(6);
    chk(16'(al_oe), 16'h0001);
    clear_all();
    chk(16'(al_oe), 16'h0000);
    wait_n(20);
    chk(16'(al_oe), 16'h0000);
    rchk(REG_STAT, 16'h0001);
    @(posedge clk_in);
    fpin <= 3'h0;
    wait_n(6);
    wr(REG_CMD, 16'h0004);
    rchk(REG_STAT, 16'h0001);
    clear_all();
    rchk(REG_STAT, 16'h0000);
    $display("monitor and clear done");
    // Alert response: lose to a lower address, then win
    wr(REG_CFG, 16'h1000);
    pulse_warn(8);
    fwa_host_model_i.ara_read(7'h08, 1'b1, d, ack, an);
    chk(16'(ack), 16'h0001);
    chk(16'(d[7:1]), 16'h0008);
    chk(16'(an), 16'h0001);
    if (al_oe === 1'b1) begin
      fwa_host_model_i.ara_read(7'h00, 1'b0, d, ack, an);
    end
    chk(16'(d[7:1]), 16'(BUS_ADDR_RESET));
    chk(16'(an), 16'h0000);
    wait_n(20);
    chk(16'(al_oe), 16'h0000);
    rchk(REG_STAT, 16'h1000);
    fwa_host_model_i.ara_read(7'h00, 1'b0, d, ack, an);
    chk(16'(ack), 16'h0000);
    wr(REG_CFG, 16'h1008);
    pulse_warn(0);
    chk(16'(al_oe), 16'h0001);
    rchk(REG_STAT, 16'h1008);
    clear_all();
    rchk(REG_STAT, 16'h0000);
    chk(16'(al_oe), 16'h0000);
    // Random own address against a random rival responder
    wr(REG_ADDR, 16'(v[6:0]));
    rchk(REG_ADDR, 16'(v[6:0]));
    pulse_warn(0);
    fwa_host_model_i.ara_read(v[13:7], 1'b1, d, ack, an);
    chk(16'(ack), 16'h0001);
    chk(16'(d[7:1]), 16'(lower(v[6:0], v[13:7])));
    chk(16'(an), 16'(v[13:7] < v[6:0]));
    clear_all();
    chk(16'(al_oe), 16'h0000);
    $display("alert response done");
    wrap_up();
  end
endmodule
